// [core/rwch_pd_merge.sv]
/*
 * merges software and packet power-down requests into registered
 * transceiver power-down controls.
 * assumes synchronous inputs on core_clk and a synchronised reset.
 */
`timescale 1ns/1ns
module rwch_pd_merge (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request sources
    rwch_pd_if.merge pd
);
    import rwch_pkg::*;

    logic [PD_W-1:0] pd_reg;
    logic [PD_W-1:0] pd_next;

    // each path powered down by software, by packet handling, or while asleep
    generate
        for (genvar i = 0; i < PD_W; i++) begin : g_pd
            assign pd_next[i] = pd.sw_pd[i] | pd.pkt_pd[i] | pd.asleep;
        end
    endgenerate

    // registered controls, all powered down from reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_reg <= '1;
        end else begin
            pd_reg <= pd_next;
        end
    end

    assign pd.pd_out = pd_reg;
endmodule : rwch_pd_merge

// [core/rwch_top.sv]
/*
 * wake handshake, reference-clock request and transceiver power-down
 * control of a short-range radio controller.
 * assumes one 125 MHz clock, host wake line and regulator enable asynchronous, other
 * controls synchronous from the controller's own logic.
 */
`timescale 1ns/1ns
module rwch_top #(
    parameter int STARTUP_CYCLES = rwch_pkg::STARTUP_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // regulator enable and host wake pin
    input wire logic radio_regulator_on,
    input wire logic host_to_device_wake,
    // configuration
    input wire logic uart_transport,
    input wire logic wake_enable,
    input wire logic [2:0] pad_func_sel,
    input wire logic host_wake_pol,
    input wire logic dev_wake_pol,
    // controller needs
    input wire logic sleep_criteria_met,
    input wire logic needs_host,
    input wire logic radio_clk_need,
    input wire logic wlan_clk_need,
    // power-down requests
    input wire logic [rwch_pkg::PD_W-1:0] sw_pd_req,
    input wire logic [rwch_pkg::PD_W-1:0] pkt_pd_req,
    // outputs
    output logic device_to_host_wake,
    output logic radio_ref_clock_request_out,
    output logic wlan_ref_clock_request_out,
    output logic [rwch_pkg::PD_W-1:0] xcvr_pd,
    output logic awake,
    output logic [1:0] state_out
);
    import rwch_pkg::*;

    // elaboration-time guard: the startup count must fit the counter
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << CNT_W)) begin : g_bad_startup
        $error("STARTUP_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_n;
    logic wake_s1_reg;
    logic wake_s2_reg;
    logic reg_s1_reg;
    logic reg_s2_reg;

    // reset released through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_reg <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_s1_reg <= 1'h1;
            rst_n <= rst_s1_reg;
        end
    end

    // pin synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_s1_reg <= 1'h0;
            wake_s2_reg <= 1'h0;
            reg_s1_reg <= 1'h0;
            reg_s2_reg <= 1'h0;
        end else begin
            wake_s1_reg <= host_to_device_wake;
            wake_s2_reg <= wake_s1_reg;
            reg_s1_reg <= radio_regulator_on;
            reg_s2_reg <= reg_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // handshake qualification
    // ------------------------------------------------------------
    wire handshake_on = uart_transport & wake_enable & (pad_func_sel == PAD_FUNC_HANDSHAKE);
    wire host_wake_act = (wake_s2_reg == host_wake_pol) & handshake_on;
    wire sleep_ok = sleep_criteria_met & ~host_wake_act;

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    rwch_state_t state_reg;
    rwch_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic clk_req_reg;
    logic clk_req_next;
    logic dev_wake_reg;
    logic dev_wake_next;

    // next state and counter
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            RWCH_OFF: begin
                cnt_next = '0;
                if (reg_s2_reg) begin
                    state_next = RWCH_STARTUP;
                end
            end
            RWCH_STARTUP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(STARTUP_CYCLES - 1)) begin
                    state_next = RWCH_AWAKE;
                    cnt_next = '0;
                end
            end
            RWCH_AWAKE: begin
                if (sleep_ok) begin
                    cnt_next = cnt_reg + 1'b1;
                end else begin
                    cnt_next = '0;
                end
                if (sleep_ok && cnt_reg >= CNT_W'(SLEEP_HOLD_CYC - 1)) begin
                    state_next = RWCH_SLEEP;
                    cnt_next = '0;
                end
            end
            RWCH_SLEEP: begin
                if (host_wake_act || needs_host || !sleep_criteria_met) begin
                    state_next = RWCH_AWAKE;
                end
            end
            default: begin
                state_next = RWCH_OFF;
                cnt_next = '0;
            end
        endcase
        if (!reg_s2_reg) begin
            state_next = RWCH_OFF;
            cnt_next = '0;
        end
    end

    // clock request: high from end of startup while awake, and while asleep when either side needs the clock
    wire powered = (state_next != RWCH_OFF) && (state_next != RWCH_STARTUP || cnt_next == '0 && state_reg != RWCH_OFF);
    always_comb begin
        clk_req_next = 1'h0;
        if (state_next == RWCH_AWAKE && state_reg == RWCH_STARTUP) begin
            clk_req_next = 1'h1;
        end else if (powered && state_next != RWCH_STARTUP) begin
            clk_req_next = radio_clk_need | wlan_clk_need | (state_next == RWCH_AWAKE);
        end
        dev_wake_next = ~dev_wake_pol; // idle level
        if (handshake_on && needs_host && state_next != RWCH_OFF) begin
            dev_wake_next = dev_wake_pol;
        end
    end

    // state registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= RWCH_OFF;
            cnt_reg <= '0;
            clk_req_reg <= 1'h0;
            dev_wake_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            clk_req_reg <= clk_req_next;
            dev_wake_reg <= dev_wake_next;
        end
    end

    // ------------------------------------------------------------
    // power-down controls
    // ------------------------------------------------------------
    rwch_pd_if pd_bus ();
    assign pd_bus.sw_pd = sw_pd_req;
    assign pd_bus.pkt_pd = pkt_pd_req;
    assign pd_bus.asleep = (state_reg != RWCH_AWAKE);

    rwch_pd_merge u_pd (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pd(pd_bus)
    );

    // outputs registered except wlan_ref_clock_request_out, which gates clk_req_reg with the clock needs; clock request always active high
    assign xcvr_pd = pd_bus.pd_out;
    assign radio_ref_clock_request_out = clk_req_reg;
    assign wlan_ref_clock_request_out = clk_req_reg & wlan_clk_need | clk_req_reg & ~radio_clk_need;
    assign device_to_host_wake = dev_wake_reg;
    assign awake = (state_reg == RWCH_AWAKE);
    assign state_out = state_reg;
endmodule : rwch_top

// [shared/rwch_pd_if.sv]
/*
 * interface carrying the power-down request sources to the power-down merger.
 * assumes both ends share core_clk.
 */
`timescale 1ns/1ns
interface rwch_pd_if;
    logic [rwch_pkg::PD_W-1:0] sw_pd;
    logic [rwch_pkg::PD_W-1:0] pkt_pd;
    logic asleep;
    logic [rwch_pkg::PD_W-1:0] pd_out;
    modport src (output sw_pd, output pkt_pd, output asleep, input pd_out);
    modport merge (input sw_pd, input pkt_pd, input asleep, output pd_out);
endinterface : rwch_pd_if

// [shared/rwch_pkg.sv]
/*
 * constants and types for the radio wake and clock-request handshake block.
 * assumes a single 125 MHz core clock.
 */
package rwch_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int STARTUP_NS = 1000;
    localparam int STARTUP_CYC = (STARTUP_NS / CLK_PERIOD_NS) < 1 ? 1 : (STARTUP_NS / CLK_PERIOD_NS);
    localparam int SLEEP_HOLD_NS = 800;
    localparam int SLEEP_HOLD_CYC = (SLEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // ------------------------------------------------------------
    // pad function and polarity encodings
    // ------------------------------------------------------------
    localparam logic [2:0] PAD_FUNC_HANDSHAKE = 3'h0;
    localparam logic POL_ACTIVE_HIGH = 1'h1;
    // power-down vector bit positions
    localparam int PD_TX = 0;
    localparam int PD_RX = 1;
    localparam int PD_PLL = 2;
    localparam int PD_PA = 3;
    localparam int PD_W = 4;

    typedef enum logic [1:0] {
        RWCH_OFF,
        RWCH_STARTUP,
        RWCH_AWAKE,
        RWCH_SLEEP
    } rwch_state_t;
endpackage : rwch_pkg

// [tb/rwch_host_model.sv]
/* host partner: drives the host wake pin, follows the device wake pin; shares core_clk */
`timescale 1ns/1ns
module rwch_host_model (
    // clock
    input wire logic core_clk,
    // wake pins, polarities and demand
    input wire logic device_to_host_wake,
    input wire logic dev_wake_pol,
    input wire logic host_wake_pol,
    input wire logic want,
    output logic host_to_device_wake,
    output logic host_awake
);
    // pin asserted at the chosen level whenever the host needs the radio
    assign host_to_device_wake = want ? host_wake_pol : !host_wake_pol;
    // host stays awake while device wake is asserted, else may sleep
    always_ff @(posedge core_clk) begin
        host_awake <= device_to_host_wake == dev_wake_pol;
    end
endmodule : rwch_host_model

// [tb/rwch_monitor.sv]
/* port checker for rwch_top; bound below to every instance of it */
`timescale 1ns/1ns
module rwch_monitor #(
    parameter int STARTUP_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic radio_regulator_on,
    input wire logic host_to_device_wake,
    input wire logic uart_transport,
    input wire logic wake_enable,
    input wire logic [2:0] pad_func_sel,
    input wire logic host_wake_pol,
    input wire logic dev_wake_pol,
    input wire logic sleep_criteria_met,
    input wire logic needs_host,
    input wire logic [3:0] sw_pd_req,
    input wire logic [3:0] pkt_pd_req,
    input wire logic device_to_host_wake,
    input wire logic radio_ref_clock_request_out,
    input wire logic [3:0] xcvr_pd,
    input wire logic awake,
    input wire logic [1:0] state_out
);
    localparam int SU_MAX = STARTUP_CYCLES + 1;
    logic [2:0] on_age_reg;
    logic [7:0] crit_reg;
    // handshake enable, settled regulator, host wake level
    wire hs_on = uart_transport && wake_enable && pad_func_sel == 3'h0;
    wire ok = on_age_reg == 3'h7;
    wire wake_act = host_to_device_wake == host_wake_pol;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // regulator-on age and run length of sleep criteria
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            on_age_reg <= 3'h0;
            crit_reg <= 8'h0;
        end else begin
            on_age_reg <= radio_regulator_on ? on_age_reg + {2'h0, !ok} : 3'h0;
            crit_reg <= sleep_criteria_met ? crit_reg + {7'h0, crit_reg != 8'hff} : 8'h0;
        end
    end
    chk_pd_request: assert property (
        1 |=> (xcvr_pd & $past(sw_pd_req | pkt_pd_req)) == $past(sw_pd_req | pkt_pd_req))
        else $error("power-down request not applied");
    chk_pd_asleep: assert property (
        !awake [*2] |-> xcvr_pd == 4'hf) else $error("paths up while not awake");
    chk_startup_req: assert property (
        $rose(state_out == 2'h1) |-> ##[1:SU_MAX] radio_ref_clock_request_out)
        else $error("clock request late after startup");
    chk_wake_exit: assert property (
        ok && hs_on && wake_act && state_out == 2'h3 |-> ##[1:4] awake) else $error("host wake ignored");
    chk_stay_awake: assert property (
        (ok && hs_on && wake_act && awake) [*3] |=> awake) else $error("slept under host wake");
    chk_sleep_hold: assert property (
        $fell(awake) && state_out == 2'h3 |-> crit_reg >= rwch_pkg::SLEEP_HOLD_CYC - 1)
        else $error("slept before criteria held");
    chk_dev_idle: assert property (
        ok && !hs_on |=> device_to_host_wake == !$past(dev_wake_pol)) else $error("device wake not idle");
    chk_dev_request: assert property (
        ok && hs_on && needs_host |=> device_to_host_wake == $past(dev_wake_pol))
        else $error("device wake not asserted");
endmodule : rwch_monitor

bind rwch_top rwch_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_rwch_monitor (.core_clk(core_clk), .rstn(rstn),
    .radio_regulator_on(radio_regulator_on), .host_to_device_wake(host_to_device_wake),
    .uart_transport(uart_transport), .wake_enable(wake_enable), .pad_func_sel(pad_func_sel),
    .host_wake_pol(host_wake_pol), .dev_wake_pol(dev_wake_pol), .sleep_criteria_met(sleep_criteria_met),
    .needs_host(needs_host), .sw_pd_req(sw_pd_req), .pkt_pd_req(pkt_pd_req),
    .device_to_host_wake(device_to_host_wake), .radio_ref_clock_request_out(radio_ref_clock_request_out),
    .xcvr_pd(xcvr_pd), .awake(awake), .state_out(state_out));

// [tb/rwch_top_test.sv]
/* self-checking bench for rwch_top; host model on the wake pins, inputs driven at the falling edge */
`timescale 1ns/1ns
module rwch_top_test;
    import rwch_pkg::*;
    localparam int SC = 4;
    logic core_clk, rstn, reg_on, uart, wen, hpol, dpol, crit, need, rneed, wneed, want;
    logic [2:0] pad;
    logic [3:0] swpd, pkpd;
    wire h2d, d2h, rreq, wreq, awk, hawk;
    wire [3:0] pd;
    wire [1:0] st;
    int n_errors = 0;
    int check_count = 0;
    rwch_top #(.STARTUP_CYCLES(SC)) i_rwch_top (.core_clk(core_clk), .rstn(rstn), .radio_regulator_on(reg_on),
        .host_to_device_wake(h2d), .uart_transport(uart), .wake_enable(wen), .pad_func_sel(pad),
        .host_wake_pol(hpol), .dev_wake_pol(dpol), .sleep_criteria_met(crit), .needs_host(need),
        .radio_clk_need(rneed), .wlan_clk_need(wneed), .sw_pd_req(swpd), .pkt_pd_req(pkpd),
        .device_to_host_wake(d2h), .radio_ref_clock_request_out(rreq), .wlan_ref_clock_request_out(wreq),
        .xcvr_pd(pd), .awake(awk), .state_out(st));
    rwch_host_model i_rwch_host_model (.core_clk(core_clk), .device_to_host_wake(d2h), .dev_wake_pol(dpol),
        .host_wake_pol(hpol), .want(want), .host_to_device_wake(h2d), .host_awake(hawk));
    // compare and count
    task check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task results;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task t_startup;
        reg_on = 1'b1;
        repeat (SC + 5) @(negedge core_clk);
        check("state", st, 4'h2);
        check("ref_req", rreq, 4'h1);
        check("wlan_req", wreq, 4'h1);
    endtask : t_startup
    task t_pd;
        for (int i = 0; i < 8; i++) begin
            swpd = (i < 4) ? 4'h1 << i : 4'h0;
            pkpd = (i < 4) ? 4'h0 : 4'h1 << (i - 4);
            @(negedge core_clk);
            check("xcvr_pd", pd, swpd | pkpd);
        end
        {swpd, pkpd} = 8'h0;
    endtask : t_pd
    task t_sleep(input logic pol);
        hpol = pol;
        crit = 1'b1;
        repeat (SLEEP_HOLD_CYC - 10) @(negedge core_clk);
        check("early", st, 4'h2);
        repeat (20) @(negedge core_clk);
        check("asleep", st, 4'h3);
        check("pd_sleep", pd, 4'hf);
        {rneed, wneed} = 2'h0;
        @(negedge core_clk);
        check("sleep_req", rreq, 4'h0);
        check("sleep_wreq", wreq, 4'h0);
        wneed = 1'b1;
        @(negedge core_clk);
        check("wlan_need_req", rreq, 4'h1);
        check("wlan_need_wreq", wreq, 4'h1);
        rneed = 1'b1;
        want = 1'b1;
        repeat (4) @(negedge core_clk);
        check("woken", awk, 4'h1);
        repeat (SLEEP_HOLD_CYC + 10) @(negedge core_clk);
        check("held", awk, 4'h1);
        {want, crit} = 2'h0;
    endtask : t_sleep
    task t_dev(input logic pol);
        dpol = pol;
        need = 1'b1;
        repeat (2) @(negedge core_clk);
        check("d2h_on", d2h, pol);
        check("host_awake", hawk, 4'h1);
        pad = 3'h1;
        @(negedge core_clk);
        check("d2h_pad", d2h, !pol);
        pad = 3'h0;
        uart = 1'b0;
        @(negedge core_clk);
        check("d2h_uart", d2h, !pol);
        uart = 1'b1;
        need = 1'b0;
        @(negedge core_clk);
        check("d2h_off", d2h, !pol);
        @(negedge core_clk);
        check("host_sleep", hawk, 4'h0);
    endtask : t_dev
    task t_off;
        reg_on = 1'b0;
        repeat (5) @(negedge core_clk);
        check("off_state", st, 4'h0);
        check("off_req", rreq, 4'h0);
        check("off_wreq", wreq, 4'h0);
    endtask : t_off
    // clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // watchdog, about ten times the expected run
    initial begin
        #40000;
        n_errors++;
        results();
    end
    // reset then scenarios
    initial begin
        rstn = 1'b0;
        {reg_on, crit, need, want, swpd, pkpd, pad} = 15'h0;
        {uart, wen, hpol, dpol, rneed, wneed} = 6'h3f;
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        t_startup();
        t_pd();
        t_sleep(1'b1);
        t_sleep(1'b0);
        t_dev(1'b1);
        t_dev(1'b0);
        t_off();
        results();
    end
endmodule : rwch_top_test
